// ### rtl/pcc_pkg.sv
/*
 pcc_pkg: constants and types for the counter array compare/capture block.
 assumes: one 100 MHz clock, apb register access with 32-bit data.
*/
package pcc_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_MODE0 = 8'h00;
   localparam logic [7:0] OFF_CAP0 = 8'h20;
   localparam logic [7:0] OFF_COUNTER = 8'h40;
   localparam logic [7:0] OFF_CNT_MODE = 8'h44;
   localparam logic [7:0] OFF_STATUS = 8'h48;
   localparam logic [7:0] OFF_IRQ_EN = 8'h4c;
   localparam logic [7:0] OFF_CLEAR = 8'h50;
   localparam logic [7:0] OFF_WD_STATUS = 8'h54;
   localparam logic [7:0] MODULE_STRIDE = 8'h04;
   // ==========================================================
   // mode register bit positions
   localparam int B_FLAG_IRQ = 0;
   localparam int B_DUTY = 1;
   localparam int B_TOGGLE = 2;
   localparam int B_MATCH = 3;
   localparam int B_FALL = 4;
   localparam int B_RISE = 5;
   localparam int B_COMPARE = 6;
   localparam int B_WD_ENABLE = 0;
   localparam int B_CNT_RUN = 1;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [6:0] MODE_WMASK = 7'h7f;
   localparam int WD_MODULE = 4;
   localparam int NUM_MODULES = 5;
   localparam int WD_PULSE_NS = 100;
   localparam int CLK_NS = 10;
   localparam int WD_PULSE_CYC = (WD_PULSE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      PCC_IDLE = 3'b000,
      PCC_CAPTURE = 3'b001,
      PCC_TIMER = 3'b010,
      PCC_HSO = 3'b011,
      PCC_PWM = 3'b100
   } pcc_mode_t;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } pcc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pcc_apb_rsp_t;
endpackage

// ### rtl/pcc_array.sv
/*
 pcc_array: five compare/capture modules around one shared 16-bit counter, apb registers,
 event flags with interrupt, module 4 watchdog reset.
 assumes: apb master on clk_in; module pins are asynchronous and are synchronised here.
*/
// Behaviour
// - rise or fall capture bit set, with match, toggle and duty clear, puts module in capture mode, watching its pin.
// - both capture bits set captures on any pin transition.
// - valid transition copies counter high and low bytes into capture pair.
// - capture or match sets event flag; interrupt needs flag and flag enable.
// - compare plus match bits give software timer; equality is a match event.
// - software timer match requests interrupt when flag and enable both set.
// - high speed output needs toggle, match, compare set and duty clear.
// - high speed output inverts module pin on every 16-bit match.
// - duty plus compare, others clear, give 8-bit pulse width output.
// - all pulse width outputs share one counter period; duties independent.
// - output low while counter low byte below active duty byte, else high.
// - on low byte wrap to zero, active duty byte reloads from reload byte.
// - only module 4 can be watchdog; otherwise usable in all modes.
// - watchdog armed by module 4 compare mode plus watchdog enable; match triggers.
// - armed match raises internal reset, never drives external reset pin.
// - clearing watchdog enable before match prevents reset; setting again re-arms.
module pcc_array #(
   parameter int NMOD = pcc_pkg::NUM_MODULES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire pcc_pkg::pcc_apb_req_t apb_req_in,
   output pcc_pkg::pcc_apb_rsp_t apb_rsp_out,
   input wire logic [NMOD-1:0] module_io_pin_in,
   output logic [NMOD-1:0] module_io_pin_out,
   output logic [NMOD-1:0] module_io_pin_oe_out,
   output logic irq_out,
   output logic wd_reset_out
);
   import pcc_pkg::*;

   // ==========================================================
   // state
   logic [7:0] module_mode_reg [NMOD];
   logic [7:0] capture_low_byte [NMOD];
   logic [7:0] capture_high_byte [NMOD];
   logic [7:0] active_duty_byte [NMOD];
   logic [NMOD-1:0] module_event_flag;
   logic [NMOD-1:0] irq_enable;
   logic [NMOD-1:0] hso_level;
   logic [NMOD-1:0] pin_meta;
   logic [NMOD-1:0] pin_sync;
   logic [NMOD-1:0] pin_prev;
   logic [NMOD-1:0] cap_event;
   logic [NMOD-1:0] match_event;
   logic [NMOD-1:0] sw_clear;
   logic [NMOD-1:0] irq_src;
   pcc_mode_t mode_of [NMOD];
   logic [15:0] counter;
   logic [7:0] counter_high_byte;
   logic [7:0] counter_low_byte;
   logic watchdog_enable;
   logic counter_run;
   logic wd_fired;
   logic [3:0] wd_pulse_cnt;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] addr;
   logic [31:0] next_rdata;
   logic addr_ok;
   logic wd_armed;

   assign counter_high_byte = counter[15:8];
   assign counter_low_byte = counter[7:0];
   assign addr = apb_req_in.paddr;
   assign wr_stb = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
   assign rd_stb = apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite;

   // ==========================================================
   // shared counter
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         counter <= 16'h0000;
      end else if (wr_stb && addr == OFF_COUNTER) begin
         counter <= apb_req_in.pwdata[15:0];
      end else if (counter_run) begin
         counter <= counter + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         watchdog_enable <= 1'b0;
         counter_run <= 1'b0;
         irq_enable <= '0;
      end else if (wr_stb && addr == OFF_CNT_MODE) begin
         watchdog_enable <= apb_req_in.pwdata[B_WD_ENABLE];
         counter_run <= apb_req_in.pwdata[B_CNT_RUN];
      end else if (wr_stb && addr == OFF_IRQ_EN) begin
         irq_enable <= apb_req_in.pwdata[NMOD-1:0];
      end
   end

   // ==========================================================
   // per module logic
   genvar g;
   generate
      for (g = 0; g < NMOD; g++) begin : gen_mod
         logic [7:0] m;
         logic wr_mode;
         logic wr_cap;
         assign m = module_mode_reg[g];
         assign wr_mode = wr_stb && addr == OFF_MODE0 + 8'(g * 4);
         assign wr_cap = wr_stb && addr == OFF_CAP0 + 8'(g * 4);

         always_comb begin
            mode_of[g] = PCC_IDLE;
            if ((m[B_RISE] || m[B_FALL]) && !m[B_MATCH] && !m[B_TOGGLE] && !m[B_DUTY]) begin
               mode_of[g] = PCC_CAPTURE;
            end else if (m[B_COMPARE] && m[B_MATCH] && m[B_TOGGLE] && !m[B_DUTY]) begin
               mode_of[g] = PCC_HSO;
            end else if (m[B_COMPARE] && m[B_MATCH] && !m[B_DUTY]) begin
               mode_of[g] = PCC_TIMER;
            end else if (m[B_COMPARE] && m[B_DUTY] && !m[B_MATCH] && !m[B_TOGGLE] && !m[B_RISE]
                         && !m[B_FALL] && !m[B_FLAG_IRQ]) begin
               mode_of[g] = PCC_PWM;
            end
         end

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               module_mode_reg[g] <= MODE_RESET;
            end else if (wr_mode) begin
               module_mode_reg[g] <= {1'b0, apb_req_in.pwdata[6:0] & MODE_WMASK};
            end
         end

         // two-stage synchroniser then edge compare
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               pin_meta[g] <= 1'b0;
               pin_sync[g] <= 1'b0;
               pin_prev[g] <= 1'b0;
            end else begin
               pin_meta[g] <= module_io_pin_in[g];
               pin_sync[g] <= pin_meta[g];
               pin_prev[g] <= pin_sync[g];
            end
         end

         assign cap_event[g] = (mode_of[g] == PCC_CAPTURE) &&
            ((m[B_RISE] && pin_sync[g] && !pin_prev[g]) ||
             (m[B_FALL] && !pin_sync[g] && pin_prev[g]));
         assign match_event[g] = m[B_COMPARE] && m[B_MATCH] && !m[B_DUTY] &&
            counter == {capture_high_byte[g], capture_low_byte[g]};

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               capture_low_byte[g] <= 8'h00;
               capture_high_byte[g] <= 8'h00;
            end else if (cap_event[g]) begin
               capture_low_byte[g] <= counter_low_byte;
               capture_high_byte[g] <= counter_high_byte;
            end else if (wr_cap) begin
               capture_low_byte[g] <= apb_req_in.pwdata[7:0];
               capture_high_byte[g] <= apb_req_in.pwdata[15:8];
            end
         end

         // event flag, set wins over clear
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               module_event_flag[g] <= 1'b0;
            end else if (cap_event[g] || match_event[g]) begin
               module_event_flag[g] <= 1'b1;
            end else if (sw_clear[g]) begin
               module_event_flag[g] <= 1'b0;
            end
         end

         // high speed toggle and pulse width output
         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               hso_level[g] <= 1'b0;
            end else if (mode_of[g] == PCC_HSO && match_event[g]) begin
               hso_level[g] <= !hso_level[g];
            end
         end

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               active_duty_byte[g] <= 8'h00;
            end else if (counter_run && counter_low_byte == 8'hff) begin
               active_duty_byte[g] <= capture_high_byte[g];
            end else if (wr_cap) begin
               active_duty_byte[g] <= apb_req_in.pwdata[7:0];
            end
         end

         always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               module_io_pin_out[g] <= 1'b0;
               module_io_pin_oe_out[g] <= 1'b0;
            end else begin
               unique case (mode_of[g])
                  PCC_HSO: begin
                     module_io_pin_out[g] <= (match_event[g]) ? !hso_level[g] : hso_level[g];
                     module_io_pin_oe_out[g] <= 1'b1;
                  end
                  PCC_PWM: begin
                     module_io_pin_out[g] <= !(counter_low_byte < active_duty_byte[g]);
                     module_io_pin_oe_out[g] <= 1'b1;
                  end
                  default: begin
                     module_io_pin_out[g] <= 1'b0;
                     module_io_pin_oe_out[g] <= 1'b0;
                  end
               endcase
            end
         end
      end
   endgenerate

   assign sw_clear = (wr_stb && addr == OFF_CLEAR) ? apb_req_in.pwdata[NMOD-1:0] : '0;
   assign irq_src = module_event_flag & irq_enable;
   assign irq_out = |irq_src;

   // ==========================================================
   // watchdog on module 4 only
   assign wd_armed = watchdog_enable && module_mode_reg[WD_MODULE][B_COMPARE] &&
      module_mode_reg[WD_MODULE][B_MATCH] && !module_mode_reg[WD_MODULE][B_DUTY];

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wd_pulse_cnt <= 4'h0;
         wd_fired <= 1'b0;
      end else if (wd_armed && match_event[WD_MODULE]) begin
         wd_pulse_cnt <= 4'(WD_PULSE_CYC);
         wd_fired <= 1'b1;
      end else if (wd_pulse_cnt != 4'h0) begin
         wd_pulse_cnt <= wd_pulse_cnt - 4'h1;
      end else if (rd_stb && addr == OFF_WD_STATUS) begin
         wd_fired <= 1'b0;
      end
   end
   assign wd_reset_out = wd_pulse_cnt != 4'h0;

   // ==========================================================
   // apb read path
   always_comb begin
      next_rdata = 32'h0000_0000;
      addr_ok = 1'b1;
      if (addr >= OFF_MODE0 && addr < OFF_MODE0 + 8'(NMOD * 4) && addr[1:0] == 2'b00) begin
         next_rdata[7:0] = module_mode_reg[3'((addr - OFF_MODE0) >> 2)];
      end else if (addr >= OFF_CAP0 && addr < OFF_CAP0 + 8'(NMOD * 4) && addr[1:0] == 2'b00) begin
         next_rdata[15:0] = {capture_high_byte[3'((addr - OFF_CAP0) >> 2)],
                             capture_low_byte[3'((addr - OFF_CAP0) >> 2)]};
      end else begin
         unique case (addr)
            OFF_COUNTER: next_rdata[15:0] = counter;
            OFF_CNT_MODE: next_rdata[1:0] = {counter_run, watchdog_enable};
            OFF_STATUS: next_rdata[NMOD-1:0] = module_event_flag;
            OFF_IRQ_EN: next_rdata[NMOD-1:0] = irq_enable;
            OFF_CLEAR: next_rdata = 32'h0000_0000;
            OFF_WD_STATUS: next_rdata[0] = wd_fired;
            default: addr_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         apb_rsp_out.prdata <= 32'h0000_0000;
         apb_rsp_out.pslverr <= 1'b0;
      end else if (apb_req_in.psel && !apb_req_in.penable) begin
         apb_rsp_out.prdata <= apb_req_in.pwrite ? 32'h0000_0000 : next_rdata;
         apb_rsp_out.pslverr <= !addr_ok;
      end
   end
   assign apb_rsp_out.pready = 1'b1;

   // ==========================================================
   // checks
   capture_copies_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cap_event[0] |=> capture_low_byte[0] == $past(counter_low_byte))
      else $error("capture did not copy counter");
   flag_sets_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (cap_event[1] || match_event[1]) |=> module_event_flag[1])
      else $error("event flag not set");
   irq_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      irq_out |-> |(module_event_flag & irq_enable))
      else $error("interrupt without enabled flag");
   hso_toggle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_of[2] == PCC_HSO && match_event[2]) |=> hso_level[2] != $past(hso_level[2]))
      else $error("toggle missed");
   pwm_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_of[3] == PCC_PWM |=> module_io_pin_out[3] == ($past(counter_low_byte) >= $past(active_duty_byte[3])))
      else $error("duty output wrong");
   duty_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (counter_run && counter_low_byte == 8'hff) |=> active_duty_byte[0] == $past(capture_high_byte[0]))
      else $error("duty byte not reloaded");
   wd_fire_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wd_armed && match_event[WD_MODULE]) |=> wd_reset_out [*8])
      else $error("watchdog reset missing");
   wd_disarm_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!watchdog_enable && !wd_reset_out) |=> !wd_reset_out)
      else $error("reset while disarmed");
   both_edges_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_of[0] == PCC_CAPTURE && module_mode_reg[0][B_RISE] && module_mode_reg[0][B_FALL]
       && pin_sync[0] != pin_prev[0]) |-> cap_event[0])
      else $error("transition not captured");
   rise_capture_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_of[1] == PCC_CAPTURE && module_mode_reg[1][B_RISE] && pin_sync[1] && !pin_prev[1]) |-> cap_event[1])
      else $error("rising edge not captured");
   cap_high_copy_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cap_event[1] |=> capture_high_byte[1] == $past(counter_high_byte))
      else $error("capture high byte wrong");
   flag_set0_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      cap_event[0] |=> module_event_flag[0])
      else $error("capture flag not set");
   flag_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (module_event_flag[0] && !sw_clear[0]) |=> module_event_flag[0])
      else $error("event flag lost");
   irq_masked_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (irq_enable == '0) |-> !irq_out)
      else $error("interrupt while all masked");
   timer_match_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mode_of[2] == PCC_TIMER && counter == {capture_high_byte[2], capture_low_byte[2]}) |-> match_event[2])
      else $error("timer match missed");
   timer_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      match_event[2] |=> module_event_flag[2])
      else $error("timer flag not set");
   hso_decode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (module_mode_reg[3][B_COMPARE] && module_mode_reg[3][B_MATCH] && module_mode_reg[3][B_TOGGLE]
       && !module_mode_reg[3][B_DUTY]) |-> mode_of[3] == PCC_HSO)
      else $error("toggle mode not decoded");
   hso_drive_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_of[3] == PCC_HSO |=> module_io_pin_oe_out[3])
      else $error("toggle pin not driven");
   hso_pin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_of[3] == PCC_HSO |=> module_io_pin_out[3] == hso_level[3])
      else $error("toggle pin level wrong");
   pwm_decode_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      module_mode_reg[0] == 8'h42 |-> mode_of[0] == PCC_PWM)
      else $error("duty mode not decoded");
   pwm_drive_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_of[0] == PCC_PWM |=> module_io_pin_oe_out[0])
      else $error("duty pin not driven");
   pwm_no_match_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_of[1] == PCC_PWM |-> !match_event[1])
      else $error("match in duty mode");
   pwm_level0_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_of[0] == PCC_PWM |=> module_io_pin_out[0] == ($past(counter_low_byte) >= $past(active_duty_byte[0])))
      else $error("duty output wrong");
   duty_reload1_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (counter_run && counter_low_byte == 8'hff) |=> active_duty_byte[1] == $past(capture_high_byte[1]))
      else $error("duty byte not reloaded");
   duty_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (counter_low_byte != 8'hff && !wr_stb) |=> $stable(active_duty_byte[0]))
      else $error("duty byte changed mid period");
   wd_only4_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wd_armed |-> module_mode_reg[WD_MODULE][B_COMPARE])
      else $error("watchdog armed outside compare");
   wd_flagged_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wd_reset_out |-> wd_fired)
      else $error("reset without status");
   wd_needs_en_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(wd_reset_out) |-> $past(watchdog_enable))
      else $error("reset without enable");
   mode_top_bit_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      module_mode_reg[0][7] == 1'b0)
      else $error("reserved mode bit set");
   sync_chain_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> pin_sync[0] == $past(pin_meta[0]))
      else $error("synchroniser chain broken");
endmodule

// ### tb/pcc_pin_model.sv
/*
 pcc_pin_model: the board side of the module pins.
 assumes: the bench asks for pin levels; the device drive wins where its enable is high.
*/
// ==========================================================
// pin source and wire resolution
module pcc_pin_model #(
   parameter int N = 5
) (
   input wire logic clk_in,
   input wire logic [N-1:0] level_in,
   input wire logic [N-1:0] pin_drive_in,
   input wire logic [N-1:0] pin_oe_in,
   output logic [N-1:0] pin_wire_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [N-1:0] ext_level = '0;
   // external source changes just after an edge
   always_ff @(posedge clk_in) ext_level <= level_in;
   assign pin_wire_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & ext_level);
endmodule

// ### tb/pcc_tb.sv
/*
 testbench: apb scenarios for the compare/capture array.
 assumes: pcc_array and pcc_pin_model compiled before; one 100 MHz clock.
*/
// ==========================================================
// bench top
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import pcc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   pcc_apb_req_t req = '0;
   pcc_apb_rsp_t rsp;
   logic [4:0] lvl = 5'h00;
   logic [4:0] pin_w;
   logic [4:0] pin_o;
   logic [4:0] pin_oe;
   logic irq;
   logic wdr;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   always #5 clk_in = ~clk_in;
   pcc_array dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .apb_req_in(req), .apb_rsp_out(rsp),
      .module_io_pin_in(pin_w), .module_io_pin_out(pin_o), .module_io_pin_oe_out(pin_oe),
      .irq_out(irq), .wd_reset_out(wdr));
   pcc_pin_model #(.N(5)) pins_u (.clk_in(clk_in), .level_in(lvl), .pin_drive_in(pin_o),
      .pin_oe_in(pin_oe), .pin_wire_out(pin_w));
   // ==========================================================
   // shared tasks
   task give_verdict;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk_in);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
      @(posedge clk_in);
      req.penable <= 1'b1;
      @(posedge clk_in);
      while (rsp.pready !== 1'b1) @(posedge clk_in);
      r = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(negedge clk_in);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rdm(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(n, x, r & m);
   endtask
   task set_cnt(input logic [15:0] v, input logic [1:0] m);
      wr(OFF_CNT_MODE, 32'h0);
      wr(OFF_COUNTER, {16'h0, v});
      wr(OFF_CLEAR, 32'h1f);
      wr(OFF_CNT_MODE, {30'h0, m});
   endtask
   // ==========================================================
   // scenarios
   task t_reset;
      logic [31:0] r;
      logic e;
      rdm("mode0 reset", OFF_MODE0, 32'hff, {24'h0, MODE_RESET});
      rdm("status reset", OFF_STATUS, 32'h1f, 32'h0);
      apb(1'b0, 8'h80, 32'h0, r, e);
      chk("unmapped err", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, r);
   endtask
   task t_capture;
      set_cnt(16'h1234, 2'b00);
      wr(OFF_MODE0, 32'h30);
      wr(OFF_MODE0 + MODULE_STRIDE, 32'h20);
      lvl <= 5'h03;
      repeat (8) @(posedge clk_in);
      rdm("cap0 rise", OFF_CAP0, 32'hffff, 32'h1234);
      rdm("flags rise", OFF_STATUS, 32'h1f, 32'h03);
      wr(OFF_COUNTER, 32'h5678);
      wr(OFF_CLEAR, 32'h1f);
      lvl <= 5'h00;
      repeat (8) @(posedge clk_in);
      rdm("cap0 fall", OFF_CAP0, 32'hffff, 32'h5678);
      rdm("flags fall", OFF_STATUS, 32'h1f, 32'h01);
   endtask
   task t_irq;
      wr(OFF_MODE0, 32'h31);
      wr(OFF_CLEAR, 32'h1f);
      wr(OFF_IRQ_EN, 32'h01);
      chk("irq idle", 32'h0, 32'(irq));
      lvl <= 5'h01;
      repeat (8) @(posedge clk_in);
      chk("irq raised", 32'h1, 32'(irq));
      wr(OFF_IRQ_EN, 32'h0);
      chk("irq masked", 32'h0, 32'(irq));
      wr(OFF_IRQ_EN, 32'h01);
      chk("irq enabled", 32'h1, 32'(irq));
      wr(OFF_CLEAR, 32'h01);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(OFF_STATUS, 32'h1f);
      rdm("status ro", OFF_STATUS, 32'h1f, 32'h0);
      rdm("clear reads", OFF_CLEAR, 32'hffffffff, 32'h0);
      wr(OFF_IRQ_EN, 32'h0);
   endtask
   task t_timer;
      set_cnt(16'h0000, 2'b00);
      wr(OFF_CAP0 + 8'h08, 32'h0010);
      wr(OFF_MODE0 + 8'h08, 32'h49);
      wr(OFF_IRQ_EN, 32'h04);
      rdm("timer early", OFF_STATUS, 32'h04, 32'h0);
      wr(OFF_CNT_MODE, 32'h2);
      repeat (30) @(posedge clk_in);
      rdm("timer match", OFF_STATUS, 32'h04, 32'h04);
      chk("timer irq", 32'h1, 32'(irq));
      wr(OFF_IRQ_EN, 32'h0);
   endtask
   task t_hso;
      set_cnt(16'h00f0, 2'b00);
      wr(OFF_CAP0 + 8'h0c, 32'h0100);
      wr(OFF_MODE0 + 8'h0c, 32'h4c);
      @(negedge clk_in);
      chk("hso oe", 32'h1, 32'(pin_oe[3]));
      chk("hso start", 32'h0, 32'(pin_o[3]));
      wr(OFF_CNT_MODE, 32'h2);
      repeat (40) @(posedge clk_in);
      chk("hso first", 32'h1, 32'(pin_o[3]));
      wr(OFF_COUNTER, 32'h00f0);
      repeat (40) @(posedge clk_in);
      chk("hso second", 32'h0, 32'(pin_o[3]));
   endtask
   task t_pwm;
      set_cnt(16'h0050, 2'b00);
      wr(OFF_CAP0, 32'h40c0);
      wr(OFF_CAP0 + 8'h04, 32'h8080);
      wr(OFF_MODE0, 32'h42);
      wr(OFF_MODE0 + 8'h04, 32'h42);
      @(negedge clk_in);
      chk("pwm oe", 32'h3, 32'(pin_oe[1:0]));
      chk("pwm below", 32'h0, 32'(pin_o[1:0]));
      wr(OFF_COUNTER, 32'h00d0);
      repeat (3) @(posedge clk_in);
      chk("pwm above", 32'h3, 32'(pin_o[1:0]));
      wr(OFF_COUNTER, 32'h00f8);
      wr(OFF_CNT_MODE, 32'h2);
      repeat (20) @(posedge clk_in);
      set_cnt(16'h0050, 2'b00);
      repeat (3) @(posedge clk_in);
      chk("pwm reload", 32'h1, 32'(pin_o[1:0]));
   endtask
   task t_wd;
      int n;
      int k;
      set_cnt(16'h0000, 2'b00);
      wr(OFF_CAP0 + 8'h10, 32'h0020);
      wr(OFF_MODE0 + 8'h10, 32'h48);
      wr(OFF_CNT_MODE, 32'h2);
      n = 0;
      repeat (60) @(posedge clk_in) if (wdr === 1'b1) n++;
      chk("wd disarmed", 32'h0, 32'(n));
      rdm("wd flag", OFF_STATUS, 32'h10, 32'h10);
      set_cnt(16'h0000, 2'b11);
      wr(OFF_CAP0 + 8'h10, 32'h0200);
      k = 0;
      while (wdr !== 1'b1 && k < 700) @(posedge clk_in) k++;
      chk("wd held off", 32'h1, 32'(k > 400 && k < 700));
      n = 0;
      while (wdr === 1'b1 && n < 100) @(posedge clk_in) n++;
      chk("wd pulse", 32'(WD_PULSE_CYC), 32'(n));
      rdm("wd status", OFF_WD_STATUS, 32'h1, 32'h1);
      rdm("wd status read", OFF_WD_STATUS, 32'h1, 32'h0);
      wr(OFF_CNT_MODE, 32'h0);
   endtask
   // ==========================================================
   // sequence and timeout
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         error_cnt++;
         $display("Error timeout expected done seen hang");
         give_verdict;
      end
   end
   initial begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset;
      t_capture;
      t_irq;
      t_timer;
      t_hso;
      t_pwm;
      t_wd;
      give_verdict;
   end
endmodule
